// ==== hdl/sfsr_cfg.svh ====
`ifndef SFSR_CFG_SVH
`define SFSR_CFG_SVH

// status byte bit positions
`define SFSR_SUM_PROT_SUMMARY    0
`define SFSR_SUM_POWERUP         1
`define SFSR_SUM_PROG_FINISHED   2
`define SFSR_SUM_CMD_ISSUE       3
`define SFSR_SUM_MULTI_UNIT      4
`define SFSR_SUM_REQ_PENDING     6

// protection register bit positions
`define SFSR_PROT_OVERVOLT       0
`define SFSR_PROT_OVERCURRENT    1
`define SFSR_PROT_OVERTEMP       2
`define SFSR_PROT_VOLT_REG       4
`define SFSR_PROT_CURR_REG       5
`define SFSR_PROT_LIMIT          6

// configuration register field positions
`define SFSR_CFG_QUICK           0
`define SFSR_CFG_CROWBAR         1
`define SFSR_CFG_EXT_OFF         2
`define SFSR_CFG_TIMING_LO       4
`define SFSR_CFG_EXT_CTRL_LO     6

// defined bit masks
`define SFSR_PROT_MASK           8'h77
`define SFSR_SRQ_COND_MASK       8'h1d

// reset values
`define SFSR_SRQ_MASK_RST        8'h00
`define SFSR_TRIP_MASK_RST       8'h00
`define SFSR_TERM_RST            2'h0
`define SFSR_HEAD_RST            1'h1
`define SFSR_PATH_RST            5'h00
`define SFSR_ERR_RST             7'h00

// multi-unit path limits
`define SFSR_PATH_ALL            5'h10

`endif

// ==== hdl/sfsr_pkg.sv ====
package sfsr_pkg;

	typedef enum logic [4:0] {
		sfsr_srq_mask_write,
		sfsr_srq_mask_read,
		sfsr_trip_enable_write,
		sfsr_trip_enable_read,
		sfsr_read_status_byte,
		sfsr_read_trip_latch,
		sfsr_read_live_trips,
		sfsr_read_config_state,
		sfsr_term_write,
		sfsr_term_read,
		sfsr_head_write,
		sfsr_head_read,
		sfsr_err_read,
		sfsr_buffer_flush,
		sfsr_trigger,
		sfsr_path_write,
		sfsr_path_read,
		sfsr_path_root
	} sfsr_cmd_t;

	typedef enum logic [1:0] {
		sfsr_term_crlf,
		sfsr_term_cr,
		sfsr_term_lf,
		sfsr_term_eoi
	} sfsr_term_t;

	typedef enum {
		sfsr_idle,
		sfsr_holdoff
	} sfsr_accept_t;

endpackage

// ==== hdl/sfsr_status_fault_srq.sv ====
`timescale 1ns/1ns
`include "sfsr_cfg.svh"

// Function
// - status byte: protection summary, powerup, finished, issue, multi-unit, request pending
// - issue bit clears on error query, buffer flush, DCL or SDC
// - request pending bit clears when the controller serial-polls
// - powerup bit in status byte reply is set from reset until a serial poll; finished bit follows the program_finished pin
// - request raised when an enabled condition in bits 0,2,3,4 rises
// - protection bits: overvolt, overcurrent, overtemp, volt reg, current reg, limit
// - protection bits latch until read by the latched query, read clears
// - protection enable bits gate the same-position protection bits
// - live protection register with same layout, own query
// - config bits: quick response, crowbar fitted, external output off
// - config bits 5:4 give output on/off timing code
// - config bits 7:6 give external control state code
// - SRQ enable register written 0-255, query returns value in decimal
// - protection enable register written 0-255, query returns decimal
// - status, latched, live and config queries return decimal
// - terminator select 0 CR+LF, 1 CR, 2 LF, 3 EOI, queryable
// - header flag adds reply header when 1, none when 0
// - DCL or SDC resets path address to 0 and clears error
// - GET message acts exactly as the trigger command
// - hold-suffixed command holds off acceptance until execution completes
// - path 0-15 or 16 for all; query at 16 reads unit 0
// - error register keeps latest code, cleared by query, flush, DCL, SDC
module sfsr_status_fault_srq (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic                 cmd_valid,
	input  wire sfsr_pkg::sfsr_cmd_t  cmd_code,
	input  wire logic [7:0]           cmd_data,
	input  wire logic                 cmd_hold,
	output logic                      cmd_ready,
	input  wire logic                 exec_done,
	output logic                      rsp_valid,
	output logic [7:0]                rsp_value,
	output logic [11:0]               rsp_bcd,
	output logic                      rsp_header,
	output logic [1:0]                rsp_term,
	output sfsr_pkg::sfsr_cmd_t       rsp_cmd,
	input  wire logic                 err_valid,
	input  wire logic [6:0]           err_code,
	input  wire logic                 gpib_clear,
	input  wire logic                 gpib_serial_poll,
	input  wire logic                 gpib_get,
	output logic                      trigger_pulse,
	output logic                      service_request,
	output logic [4:0]                path_addr,
	output logic [3:0]                reply_unit,
	input  wire logic                 overvolt_trip,
	input  wire logic                 overcurrent_trip,
	input  wire logic                 overtemp_trip,
	input  wire logic                 volt_regulating,
	input  wire logic                 current_regulating,
	input  wire logic                 limit_active,
	input  wire logic                 program_finished,
	input  wire logic                 multi_unit_link,
	input  wire logic                 quick_response,
	input  wire logic                 crowbar_fitted,
	input  wire logic                 ext_output_disable,
	input  wire logic                 onoff_timing_lo,
	input  wire logic                 onoff_timing_hi,
	input  wire logic                 ext_ctrl_state_lo,
	input  wire logic                 ext_ctrl_state_hi
);

	//****************************************************************
	// pin synchronisers
	//****************************************************************
	localparam int SYNC_W = 15;

	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_meta_q;
	logic [SYNC_W-1:0] pin_q;

	assign pin_raw = {ext_ctrl_state_hi, ext_ctrl_state_lo,
		onoff_timing_hi, onoff_timing_lo, ext_output_disable,
		crowbar_fitted, quick_response, multi_unit_link,
		program_finished, limit_active, current_regulating,
		volt_regulating, overtemp_trip, overcurrent_trip,
		overvolt_trip};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta_q <= '0;
			pin_q      <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q      <= pin_meta_q;
		end
	end

	//****************************************************************
	// decoded live views
	//****************************************************************
	logic [7:0] live_prot;
	logic [7:0] config_state;
	logic       fin_live;
	logic       link_live;

	always_comb begin
		live_prot = 8'h00;
		live_prot[`SFSR_PROT_OVERVOLT]    = pin_q[0];
		live_prot[`SFSR_PROT_OVERCURRENT] = pin_q[1];
		live_prot[`SFSR_PROT_OVERTEMP]    = pin_q[2];
		live_prot[`SFSR_PROT_VOLT_REG]    = pin_q[3];
		live_prot[`SFSR_PROT_CURR_REG]    = pin_q[4];
		live_prot[`SFSR_PROT_LIMIT]       = pin_q[5];
	end

	assign fin_live = pin_q[6];
	assign link_live = pin_q[7];

	always_comb begin
		config_state = 8'h00;
		config_state[`SFSR_CFG_QUICK]   = pin_q[8];
		config_state[`SFSR_CFG_CROWBAR] = pin_q[9];
		config_state[`SFSR_CFG_EXT_OFF] = pin_q[10];
		config_state[`SFSR_CFG_TIMING_LO +: 2]   = pin_q[12:11];
		config_state[`SFSR_CFG_EXT_CTRL_LO +: 2] = pin_q[14:13];
	end

	//****************************************************************
	// command acceptance and hold-off
	//****************************************************************
	sfsr_pkg::sfsr_accept_t acc_q;
	logic                   take;

	assign take = cmd_valid && cmd_ready;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_q     <= sfsr_pkg::sfsr_idle;
			cmd_ready <= 1'b1;
		end else begin
			case (acc_q)
				sfsr_pkg::sfsr_idle: begin
					if (take && cmd_hold) begin
						acc_q     <= sfsr_pkg::sfsr_holdoff;
						cmd_ready <= 1'b0;
					end
				end
				sfsr_pkg::sfsr_holdoff: begin
					if (exec_done) begin
						acc_q     <= sfsr_pkg::sfsr_idle;
						cmd_ready <= 1'b1;
					end
				end
				default: begin
					acc_q     <= sfsr_pkg::sfsr_idle;
					cmd_ready <= 1'b1;
				end
			endcase
		end
	end

	logic is_cmd;
	logic clr_issue;

	function automatic logic hit(input sfsr_pkg::sfsr_cmd_t c,
		input sfsr_pkg::sfsr_cmd_t want);
		hit = (c == want);
	endfunction

	assign is_cmd    = take;
	assign clr_issue = (is_cmd && (hit(cmd_code, sfsr_pkg::sfsr_err_read) ||
		hit(cmd_code, sfsr_pkg::sfsr_buffer_flush))) || gpib_clear;

	//****************************************************************
	// writable settings
	//****************************************************************
	logic [7:0] srq_enable_mask_q;
	logic [7:0] protection_enable_mask_q;
	logic [1:0] term_q;
	logic       head_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			srq_enable_mask_q        <= `SFSR_SRQ_MASK_RST;
			protection_enable_mask_q <= `SFSR_TRIP_MASK_RST;
			term_q                   <= `SFSR_TERM_RST;
			head_q                   <= `SFSR_HEAD_RST;
		end else if (is_cmd) begin
			case (cmd_code)
				sfsr_pkg::sfsr_srq_mask_write:
					srq_enable_mask_q <= cmd_data;
				sfsr_pkg::sfsr_trip_enable_write:
					protection_enable_mask_q <= cmd_data;
				sfsr_pkg::sfsr_term_write:
					if (cmd_data[7:2] == 6'h00) begin
						term_q <= cmd_data[1:0];
					end
				sfsr_pkg::sfsr_head_write:
					if (cmd_data[7:1] == 7'h00) begin
						head_q <= cmd_data[0];
					end
				default: begin
				end
			endcase
		end
	end

	//****************************************************************
	// multi-unit path address
	//****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			path_addr  <= `SFSR_PATH_RST;
			reply_unit <= 4'h0;
		end else if (gpib_clear) begin
			path_addr  <= `SFSR_PATH_RST;
			reply_unit <= 4'h0;
		end else if (is_cmd && hit(cmd_code, sfsr_pkg::sfsr_path_root)) begin
			path_addr  <= `SFSR_PATH_RST;
			reply_unit <= 4'h0;
		end else if (is_cmd && hit(cmd_code, sfsr_pkg::sfsr_path_write) &&
			cmd_data <= {3'h0, `SFSR_PATH_ALL}) begin
			path_addr  <= cmd_data[4:0];
			reply_unit <= cmd_data[4] ? 4'h0 : cmd_data[3:0];
		end
	end

	//****************************************************************
	// error register
	//****************************************************************
	logic [6:0] err_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			err_q <= `SFSR_ERR_RST;
		end else if (err_valid) begin
			err_q <= err_code;
		end else if (clr_issue) begin
			err_q <= `SFSR_ERR_RST;
		end
	end

	//****************************************************************
	// latched protection events
	//****************************************************************
	logic [7:0] latched_protection_events_q;
	logic       trip_read;

	assign trip_read = is_cmd && hit(cmd_code, sfsr_pkg::sfsr_read_trip_latch);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			latched_protection_events_q <= 8'h00;
		end else begin
			latched_protection_events_q <=
				((trip_read ? 8'h00 : latched_protection_events_q) |
				live_prot) & `SFSR_PROT_MASK;
		end
	end

	//****************************************************************
	// status byte
	//****************************************************************
	logic       issue_q;
	logic       powerup_flag_q;
	logic       request_pending_q;
	logic       prot_summary;
	logic [7:0] status_summary_byte;
	logic [7:0] srq_cond;
	logic [7:0] srq_cond_prev_q;
	logic       srq_rise;

	assign prot_summary = |(latched_protection_events_q &
		protection_enable_mask_q);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			issue_q <= 1'b0;
		end else if (err_valid) begin
			issue_q <= 1'b1;
		end else if (clr_issue) begin
			issue_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			powerup_flag_q <= 1'b1;
		end else if (gpib_serial_poll) begin
			powerup_flag_q <= 1'b0;
		end
	end

	always_comb begin
		status_summary_byte = 8'h00;
		status_summary_byte[`SFSR_SUM_PROT_SUMMARY]  = prot_summary;
		status_summary_byte[`SFSR_SUM_POWERUP]       = powerup_flag_q;
		status_summary_byte[`SFSR_SUM_PROG_FINISHED] = fin_live;
		status_summary_byte[`SFSR_SUM_CMD_ISSUE]     = issue_q;
		status_summary_byte[`SFSR_SUM_MULTI_UNIT]    = link_live;
		status_summary_byte[`SFSR_SUM_REQ_PENDING]   = request_pending_q;
	end

	assign srq_cond = status_summary_byte & srq_enable_mask_q &
		`SFSR_SRQ_COND_MASK;
	assign srq_rise = |(srq_cond & ~srq_cond_prev_q);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			srq_cond_prev_q   <= 8'h00;
			request_pending_q <= 1'b0;
			service_request   <= 1'b0;
		end else begin
			srq_cond_prev_q <= srq_cond;
			if (srq_rise) begin
				request_pending_q <= 1'b1;
				service_request   <= 1'b1;
			end else if (gpib_serial_poll) begin
				request_pending_q <= 1'b0;
				service_request   <= 1'b0;
			end
		end
	end

	//****************************************************************
	// trigger
	//****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trigger_pulse <= 1'b0;
		end else begin
			trigger_pulse <= gpib_get ||
				(is_cmd && hit(cmd_code, sfsr_pkg::sfsr_trigger));
		end
	end

	//****************************************************************
	// query replies
	//****************************************************************
	function automatic logic [11:0] to_bcd(input logic [7:0] v);
		logic [19:0] s;
		s = {12'h000, v};
		for (int i = 0; i < 8; i++) begin
			if (s[11:8] > 4'h4) s[11:8] = s[11:8] + 4'h3;
			if (s[15:12] > 4'h4) s[15:12] = s[15:12] + 4'h3;
			if (s[19:16] > 4'h4) s[19:16] = s[19:16] + 4'h3;
			s = {s[18:0], 1'b0};
		end
		to_bcd = s[19:8];
	endfunction

	logic [7:0] q_val;
	logic       q_hit;

	always_comb begin
		q_val = 8'h00;
		q_hit = 1'b1;
		case (cmd_code)
			sfsr_pkg::sfsr_srq_mask_read:     q_val = srq_enable_mask_q;
			sfsr_pkg::sfsr_trip_enable_read:
				q_val = protection_enable_mask_q;
			sfsr_pkg::sfsr_read_status_byte:  q_val = status_summary_byte;
			sfsr_pkg::sfsr_read_trip_latch:
				q_val = latched_protection_events_q;
			sfsr_pkg::sfsr_read_live_trips:   q_val = live_prot;
			sfsr_pkg::sfsr_read_config_state: q_val = config_state;
			sfsr_pkg::sfsr_term_read:         q_val = {6'h00, term_q};
			sfsr_pkg::sfsr_head_read:         q_val = {7'h00, head_q};
			sfsr_pkg::sfsr_err_read:          q_val = {1'b0, err_q};
			sfsr_pkg::sfsr_path_read:         q_val = {3'h0, path_addr};
			default:                          q_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid  <= 1'b0;
			rsp_value  <= 8'h00;
			rsp_bcd    <= 12'h000;
			rsp_header <= `SFSR_HEAD_RST;
			rsp_term   <= `SFSR_TERM_RST;
			rsp_cmd    <= sfsr_pkg::sfsr_srq_mask_write;
		end else begin
			rsp_valid <= is_cmd && q_hit;
			if (is_cmd && q_hit) begin
				rsp_value  <= q_val;
				rsp_bcd    <= to_bcd(q_val);
				rsp_header <= head_q;
				rsp_term   <= term_q;
				rsp_cmd    <= cmd_code;
			end
		end
	end

endmodule

// ==== test/sfsr_chk_properties.sv ====
`timescale 1ns/1ns
module sfsr_chk (
	input logic                 core_clk,
	input logic                 rstn,
	input logic                 cmd_valid,
	input sfsr_pkg::sfsr_cmd_t  cmd_code,
	input logic                 cmd_hold,
	input logic                 cmd_ready,
	input logic                 exec_done,
	input logic                 rsp_valid,
	input logic [7:0]           rsp_value,
	input logic [11:0]          rsp_bcd,
	input sfsr_pkg::sfsr_cmd_t  rsp_cmd,
	input logic                 gpib_get,
	input logic                 gpib_clear,
	input logic                 trigger_pulse,
	input logic [4:0]           path_addr,
	input logic [3:0]           reply_unit
);
	logic take;
	logic trig_req;
	assign take = cmd_valid && cmd_ready;
	assign trig_req = gpib_get ||
		(take && cmd_code == sfsr_pkg::sfsr_trigger);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_hold_take;
		take && cmd_hold;
	endsequence
	sequence s_hold_wait;
		s_hold_take ##1 !exec_done;
	endsequence
	chk_trig_answer: assert property (trig_req |=> trigger_pulse)
		else $error("trigger pulse missing");
	chk_trig_cause: assert property (trigger_pulse |-> $past(trig_req))
		else $error("trigger pulse without cause");
	chk_rsp_cause: assert property (rsp_valid |-> $past(take))
		else $error("answer without command");
	chk_rsp_echo: assert property (rsp_valid |-> rsp_cmd == $past(cmd_code))
		else $error("answer code mismatch");
	chk_rsp_digits: assert property (rsp_valid |-> rsp_bcd ==
		{4'(rsp_value / 100), 4'(rsp_value / 10 % 10), 4'(rsp_value % 10)})
		else $error("decimal digits wrong");
	chk_path_clear: assert property (gpib_clear && !cmd_valid
		|=> path_addr == 5'h00)
		else $error("path not cleared");
	chk_unit_map: assert property (path_addr <= 5'h10 && reply_unit ==
		(path_addr == 5'h10 ? 4'h0 : path_addr[3:0]))
		else $error("reply unit wrong");
	chk_hold_block: assert property (s_hold_wait |=> !cmd_ready)
		else $error("hold not applied");
	chk_hold_release: assert property (!cmd_ready && exec_done |=> cmd_ready)
		else $error("hold not released");
endmodule
bind sfsr_status_fault_srq sfsr_chk u_chk (
	.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_hold(cmd_hold), .cmd_ready(cmd_ready),
	.exec_done(exec_done), .rsp_valid(rsp_valid), .rsp_value(rsp_value),
	.rsp_bcd(rsp_bcd), .rsp_cmd(rsp_cmd), .gpib_get(gpib_get),
	.gpib_clear(gpib_clear), .trigger_pulse(trigger_pulse),
	.path_addr(path_addr), .reply_unit(reply_unit)
);

// ==== test/sfsr_ctl_model.sv ====
`timescale 1ns/1ns
module sfsr_ctl_model (
	input  logic                 core_clk,
	input  logic                 cmd_ready,
	output logic                 cmd_valid,
	output sfsr_pkg::sfsr_cmd_t  cmd_code,
	output logic [7:0]           cmd_data,
	output logic                 cmd_hold
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = sfsr_pkg::sfsr_err_read;
		cmd_data = 8'h00;
		cmd_hold = 1'b0;
	end
	// unused enable bits go out as zero
	task send(sfsr_pkg::sfsr_cmd_t c, logic [7:0] d, logic h);
		@(posedge core_clk);
		#1;
		cmd_code = c;
		cmd_data = c == sfsr_pkg::sfsr_srq_mask_write ? d & 8'h1d :
			c == sfsr_pkg::sfsr_trip_enable_write ? d & 8'h77 : d;
		cmd_hold = h;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		cmd_data = ~cmd_data;
		cmd_hold = ~h;
	endtask
endmodule

// ==== test/tb_status_fault_srq_registers.sv ====
`timescale 1ns/1ns
module tb_status_fault_srq_registers;
	logic core_clk = 0, rstn = 0, exec_done = 0, err_valid = 0;
	logic gpib_clear = 0, gpib_serial_poll = 0, gpib_get = 0;
	logic fin = 0, link = 0;
	logic [6:0] err_code = 7'h00, pv = 7'h00;
	logic [7:0] cf = 8'h00, cmd_data, rsp_value;
	logic cmd_valid, cmd_hold, cmd_ready, rsp_valid, rsp_header;
	logic trigger_pulse, service_request;
	logic [11:0] rsp_bcd;
	logic [1:0] rsp_term;
	logic [4:0] path_addr;
	logic [3:0] reply_unit;
	sfsr_pkg::sfsr_cmd_t cmd_code, rsp_cmd;
	int err_count = 0, cmp_count = 0, cyc = 0;
	always #5 core_clk = ~core_clk;
	sfsr_ctl_model ctl_u (.core_clk(core_clk), .cmd_ready(cmd_ready),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.cmd_hold(cmd_hold));
	sfsr_status_fault_srq dut_u (.core_clk(core_clk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.cmd_hold(cmd_hold), .cmd_ready(cmd_ready), .exec_done(exec_done),
		.rsp_valid(rsp_valid), .rsp_value(rsp_value), .rsp_bcd(rsp_bcd),
		.rsp_header(rsp_header), .rsp_term(rsp_term), .rsp_cmd(rsp_cmd),
		.err_valid(err_valid), .err_code(err_code), .gpib_clear(gpib_clear),
		.gpib_serial_poll(gpib_serial_poll), .gpib_get(gpib_get),
		.trigger_pulse(trigger_pulse), .service_request(service_request),
		.path_addr(path_addr), .reply_unit(reply_unit),
		.overvolt_trip(pv[0]), .overcurrent_trip(pv[1]),
		.overtemp_trip(pv[2]), .volt_regulating(pv[4]),
		.current_regulating(pv[5]), .limit_active(pv[6]),
		.program_finished(fin), .multi_unit_link(link),
		.quick_response(cf[0]), .crowbar_fitted(cf[1]),
		.ext_output_disable(cf[2]), .onoff_timing_lo(cf[4]),
		.onoff_timing_hi(cf[5]), .ext_ctrl_state_lo(cf[6]),
		.ext_ctrl_state_hi(cf[7]));
	// ********************
	// helpers
	// ********************
	task tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task chk(string n, logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task q(sfsr_pkg::sfsr_cmd_t c, logic [7:0] d);
		ctl_u.send(c, d, 1'b0);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			report_and_stop;
		end
	end
	// ********************
	// scenarios
	// ********************
	task t_masks;
		q(sfsr_pkg::sfsr_srq_mask_write, 8'hff);
		q(sfsr_pkg::sfsr_srq_mask_read, 8'h00);
		chk("srq mask", rsp_value, 8'h1d);
		chk("srq bcd", rsp_bcd[7:0], 8'h29);
		chk("rsp valid", 8'(rsp_valid), 8'h01);
		q(sfsr_pkg::sfsr_trip_enable_write, 8'h77);
		q(sfsr_pkg::sfsr_trip_enable_read, 8'h00);
		chk("trip mask", rsp_value, 8'h77);
		chk("trip bcd", rsp_bcd[11:4], 8'h11);
		tick(1);
		chk("rsp pulse", 8'(rsp_valid), 8'h00);
		q(sfsr_pkg::sfsr_srq_mask_write, 8'h00);
		q(sfsr_pkg::sfsr_trip_enable_write, 8'h00);
		$display("test masks done");
	endtask
	task t_prot;
		for (int b = 0; b < 7; b++) begin
			if (b != 3) begin
				pv = 7'h01 << b;
				tick(3);
				q(sfsr_pkg::sfsr_read_live_trips, 8'h00);
				chk("live", rsp_value, 8'h01 << b);
				pv = 7'h00;
				tick(3);
				q(sfsr_pkg::sfsr_read_trip_latch, 8'h00);
				chk("latched", rsp_value, 8'h01 << b);
				q(sfsr_pkg::sfsr_read_trip_latch, 8'h00);
				chk("cleared", rsp_value, 8'h00);
			end
		end
		$display("test protection done");
	endtask
	task t_srq;
		q(sfsr_pkg::sfsr_srq_mask_write, 8'h01);
		q(sfsr_pkg::sfsr_trip_enable_write, 8'h01);
		pv = 7'h01;
		tick(5);
		chk("srq", 8'(service_request), 8'h01);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("stb", 8'(rsp_value & 8'h41), 8'h41);
		pulse(gpib_serial_poll);
		tick(1);
		chk("srq poll", 8'(service_request), 8'h00);
		pv = 7'h00;
		tick(3);
		q(sfsr_pkg::sfsr_read_trip_latch, 8'h00);
		q(sfsr_pkg::sfsr_trip_enable_write, 8'h00);
		pv = 7'h02;
		tick(5);
		chk("srq masked", 8'(service_request), 8'h00);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("stb masked", 8'(rsp_value[0]), 8'h00);
		pv = 7'h00;
		tick(3);
		q(sfsr_pkg::sfsr_read_trip_latch, 8'h00);
		$display("test request done");
	endtask
	task t_err;
		q(sfsr_pkg::sfsr_srq_mask_write, 8'h08);
		err_code = 7'h4f;
		pulse(err_valid);
		tick(1);
		chk("srq err", 8'(service_request), 8'h01);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("issue", 8'(rsp_value[3]), 8'h01);
		q(sfsr_pkg::sfsr_err_read, 8'h00);
		chk("err code", rsp_value, 8'h4f);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("issue query", 8'(rsp_value[3]), 8'h00);
		err_code = 7'h02;
		pulse(err_valid);
		pulse(gpib_clear);
		q(sfsr_pkg::sfsr_err_read, 8'h00);
		chk("err clear", rsp_value, 8'h00);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("issue clear", 8'(rsp_value[3]), 8'h00);
		err_code = 7'h01;
		pulse(err_valid);
		q(sfsr_pkg::sfsr_buffer_flush, 8'h00);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("issue flush", 8'(rsp_value[3]), 8'h00);
		q(sfsr_pkg::sfsr_err_read, 8'h00);
		chk("err flush", rsp_value, 8'h00);
		pulse(gpib_serial_poll);
		$display("test error done");
	endtask
	task t_cond;
		q(sfsr_pkg::sfsr_srq_mask_write, 8'h14);
		fin = 1'b1;
		tick(4);
		chk("srq finished", 8'(service_request), 8'h01);
		pulse(gpib_serial_poll);
		chk("poll finished", 8'(service_request), 8'h00);
		link = 1'b1;
		tick(4);
		chk("srq link", 8'(service_request), 8'h01);
		q(sfsr_pkg::sfsr_read_status_byte, 8'h00);
		chk("link bit", 8'(rsp_value[4]), 8'h01);
		pulse(gpib_serial_poll);
		fin = 1'b0;
		link = 1'b0;
		tick(3);
		$display("test condition done");
	endtask
	task t_cfg;
		logic [7:0] v [3] = '{8'h67, 8'hb3, 8'hc4};
		for (int i = 0; i < 3; i++) begin
			cf = v[i];
			tick(3);
			q(sfsr_pkg::sfsr_read_config_state, 8'h00);
			chk("config", rsp_value, v[i]);
		end
		for (int i = 0; i < 5; i++) begin
			q(sfsr_pkg::sfsr_term_write, 8'(i));
			q(sfsr_pkg::sfsr_term_read, 8'h00);
			chk("term", rsp_value, i < 4 ? 8'(i) : 8'h03);
			chk("term out", 8'(rsp_term), i < 4 ? 8'(i) : 8'h03);
		end
		for (int i = 0; i < 2; i++) begin
			q(sfsr_pkg::sfsr_head_write, 8'(i));
			q(sfsr_pkg::sfsr_head_read, 8'h00);
			chk("head", rsp_value, 8'(i));
			chk("head out", 8'(rsp_header), 8'(i));
		end
		$display("test config done");
	endtask
	task t_path;
		q(sfsr_pkg::sfsr_path_write, 8'h10);
		chk("path all", 8'(path_addr), 8'h10);
		chk("unit all", 8'(reply_unit), 8'h00);
		q(sfsr_pkg::sfsr_path_read, 8'h00);
		chk("path read", rsp_value, 8'h10);
		q(sfsr_pkg::sfsr_path_write, 8'h11);
		chk("path over", 8'(path_addr), 8'h10);
		q(sfsr_pkg::sfsr_path_write, 8'h05);
		chk("unit", 8'(reply_unit), 8'h05);
		pulse(gpib_clear);
		chk("path clear", 8'(path_addr), 8'h00);
		q(sfsr_pkg::sfsr_path_write, 8'h07);
		q(sfsr_pkg::sfsr_path_root, 8'h00);
		chk("path root", 8'(path_addr), 8'h00);
		pulse(gpib_get);
		chk("get", 8'(trigger_pulse), 8'h01);
		tick(1);
		chk("get end", 8'(trigger_pulse), 8'h00);
		q(sfsr_pkg::sfsr_trigger, 8'h00);
		chk("trigger", 8'(trigger_pulse), 8'h01);
		$display("test path done");
	endtask
	task t_hold;
		ctl_u.send(sfsr_pkg::sfsr_srq_mask_write, 8'h10, 1'b1);
		tick(3);
		chk("held", 8'(cmd_ready), 8'h00);
		pulse(exec_done);
		chk("released", 8'(cmd_ready), 8'h01);
		q(sfsr_pkg::sfsr_srq_mask_read, 8'h00);
		chk("held write", rsp_value, 8'h10);
		$display("test hold done");
	endtask
	initial begin
		tick(2);
		rstn = 1'b1;
		chk("ready", 8'(cmd_ready), 8'h01);
		chk("term rst", 8'(rsp_term), 8'h00);
		chk("head rst", 8'(rsp_header), 8'h01);
		chk("path rst", 8'(path_addr), 8'h00);
		t_masks;
		t_prot;
		t_srq;
		t_err;
		t_cond;
		t_cfg;
		t_path;
		t_hold;
		report_and_stop;
	end
endmodule
